/* File: verilog/dcq_pkg.sv */
package dcq_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] DCQ_CTRL_A_OFF = 8'h00; // comparator_control_reg, comparator_zero
  localparam logic [7:0] DCQ_MODE_A_OFF = 8'h04; // comparator_mode_reg, comparator_zero
  localparam logic [7:0] DCQ_CTRL_B_OFF = 8'h08; // comparator_control_reg, comparator_one
  localparam logic [7:0] DCQ_MODE_B_OFF = 8'h0c; // comparator_mode_reg, comparator_one
  localparam logic [7:0] DCQ_GLOB_OFF   = 8'h10; // Global interrupt and source enables

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int DCQ_ON_BIT   = 7; // comparator_on_bit
  localparam int DCQ_OUT_BIT  = 6; // result_status_bit, read only
  localparam int DCQ_RIF_BIT  = 5; // rise_edge_flag
  localparam int DCQ_FIF_BIT  = 4; // fall_edge_flag
  localparam int DCQ_HYP_LSB  = 2; // pos_hysteresis_field
  localparam int DCQ_HYN_LSB  = 0; // neg_hysteresis_field

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int DCQ_RSV_BIT  = 7; // Reads one
  localparam int DCQ_RIE_BIT  = 5; // rise_irq_enable
  localparam int DCQ_FIE_BIT  = 4; // fall_irq_enable
  localparam int DCQ_MD_LSB   = 0; // response_time_field

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DCQ_CTRL_RST = 8'h00;
  localparam logic [7:0] DCQ_MODE_RST = 8'h82;
  localparam logic [1:0] DCQ_GLOB_RST = 2'h0;

  // Hysteresis and response settings decoded for the analog core
  typedef enum logic [1:0] {
    DCQ_HYS_OFF = 2'b00,
    DCQ_HYS_1   = 2'b01,
    DCQ_HYS_2   = 2'b10,
    DCQ_HYS_MAX = 2'b11
  } dcq_hys_e;

  typedef enum logic [1:0] {
    DCQ_MD_FAST = 2'b00,
    DCQ_MD_1    = 2'b01,
    DCQ_MD_2    = 2'b10,
    DCQ_MD_LOWP = 2'b11
  } dcq_md_e;
endpackage : dcq_pkg

/* File: verilog/dcq_top.sv */
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Enabled comparator result is one when positive input exceeds negative input.
// - Disabled comparator forces raw and synchronised results to zero.
// - Raw result passes a two-flop system clock synchroniser.
// - Synchronised result is read-only status, irq source, and crossbar output.
// - Raw unsynchronised result feeds wake-up and reset decision logic.
// - Raw result reaches the port pin combinationally, without clock.
// - Both rising and falling transitions of the result are detected.
// - Each comparator has separate rising and falling edge flags.
// - Edge flags set on detection regardless of interrupt enables.
// - Edge flags stay set until software writes them clear.
// - Mode register holds separate rising and falling interrupt enables.
// - Irq only when enabled flag set, source enabled, global enabled.
// - Both comparators share identical output, flag and interrupt logic.
// - Input pin selection comes only from software registers.
// - Hysteresis fields decode 00 off, 01 to 11 rising to maximum.
// - Two-bit mode selects response time, 0 fastest to 3 lowest power.
module dcq_top
  import dcq_pkg::*;
#(
  parameter int N_CMP = 2,
  parameter int SEL_W = 4
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [7:0]         haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic [N_CMP-1:0]   analog_gt,
  output logic [N_CMP-1:0]        core_enable,
  output logic [2*N_CMP-1:0]      pos_hysteresis_field,
  output logic [2*N_CMP-1:0]      neg_hysteresis_field,
  output logic [2*N_CMP-1:0]      response_time_field,
  output logic [SEL_W*N_CMP-1:0]  pos_pin_select,
  output logic [SEL_W*N_CMP-1:0]  neg_pin_select,
  output logic [N_CMP-1:0]        raw_result,
  output logic [N_CMP-1:0]        sync_result,
  output logic                    cmp_irq
);

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero-wait, always OKAY
  // ----------------------------------------------------------------
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_word;
  logic        glob_irq_en_r;
  logic        src_en_r;
  logic [N_CMP-1:0] rise_flag_r;
  logic [N_CMP-1:0] fall_flag_r;
  logic [N_CMP-1:0] sync_q_r;

  // Address phase qualification
  wire         addr_ok  = hsel & hready & htrans[1];
  wire         rd_take  = addr_ok & ~hwrite;
  wire         wr_take  = addr_ok & hwrite;
  wire         glob_wr  = wr_pend_r & (wr_addr_r == DCQ_GLOB_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_take;
      if (wr_take) begin
        wr_addr_r <= haddr;
      end
      if (rd_take) begin
        hrdata_r <= rd_word;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Global interrupt enable and comparator source enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      glob_irq_en_r <= DCQ_GLOB_RST[1];
      src_en_r      <= DCQ_GLOB_RST[0];
    end else if (glob_wr) begin
      glob_irq_en_r <= hwdata[1];
      src_en_r      <= hwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Per comparator channel, identical for both
  // ----------------------------------------------------------------
  logic [31:0] ctrl_word [N_CMP];
  logic [31:0] mode_word [N_CMP];
  logic [31:0] sel_word  [N_CMP];
  logic [N_CMP-1:0] irq_term;

  genvar g;
  generate
    for (g = 0; g < N_CMP; g++) begin : g_cmp
      logic [7:0] ctrl_r;
      logic [7:0] mode_r;
      logic [2*SEL_W-1:0] sel_r;
      logic       sync1_r;
      logic       sync2_r;
      wire  [7:0] ctrl_off = 8'(g * 8);
      wire        ctrl_wr  = wr_pend_r & (wr_addr_r == ctrl_off);
      wire        mode_wr  = wr_pend_r & (wr_addr_r == 8'(ctrl_off + 8'h04));
      wire        sel_wr   = wr_pend_r & (wr_addr_r == 8'(ctrl_off + 8'h20));
      wire        on       = ctrl_r[DCQ_ON_BIT];
      wire        rise_det = sync2_r & ~sync_q_r[g];
      wire        fall_det = ~sync2_r & sync_q_r[g];
      wire        rise_clr = ctrl_wr & ~hwdata[DCQ_RIF_BIT];
      wire        fall_clr = ctrl_wr & ~hwdata[DCQ_FIF_BIT];

      // Raw path is pure gating so it survives a stopped clock
      assign raw_result[g]  = on & analog_gt[g];
      assign core_enable[g] = on;

      // Configuration registers; flag bits live separately
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctrl_r <= DCQ_CTRL_RST;
          mode_r <= DCQ_MODE_RST;
          sel_r  <= '0;
        end else begin
          if (ctrl_wr) begin
            ctrl_r <= {hwdata[7], 3'b000, hwdata[3:0]};
          end
          if (mode_wr) begin
            mode_r <= {1'b1, 1'b0, hwdata[5:4], 2'b00, hwdata[1:0]};
          end
          if (sel_wr) begin
            sel_r <= hwdata[2*SEL_W-1:0];
          end
        end
      end

      // Two-flop synchroniser; disabled comparator clears it
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_r     <= 1'b0;
          sync2_r     <= 1'b0;
          sync_q_r[g] <= 1'b0;
        end else begin
          sync1_r     <= raw_result[g];
          sync2_r     <= on & sync1_r;
          sync_q_r[g] <= sync2_r;
        end
      end

      // Sticky flags: set beats clear, set ignores enables
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rise_flag_r[g] <= 1'b0;
          fall_flag_r[g] <= 1'b0;
        end else begin
          if (rise_det) begin
            rise_flag_r[g] <= 1'b1;
          end else if (rise_clr) begin
            rise_flag_r[g] <= 1'b0;
          end
          if (fall_det) begin
            fall_flag_r[g] <= 1'b1;
          end else if (fall_clr) begin
            fall_flag_r[g] <= 1'b0;
          end
        end
      end

      assign sync_result[g] = sync2_r;
      assign pos_hysteresis_field[2*g+1:2*g] = ctrl_r[DCQ_HYP_LSB+1:DCQ_HYP_LSB];
      assign neg_hysteresis_field[2*g+1:2*g] = ctrl_r[DCQ_HYN_LSB+1:DCQ_HYN_LSB];
      assign response_time_field[2*g+1:2*g]  = mode_r[DCQ_MD_LSB+1:DCQ_MD_LSB];
      assign pos_pin_select[SEL_W*g+SEL_W-1:SEL_W*g] = sel_r[SEL_W-1:0];
      assign neg_pin_select[SEL_W*g+SEL_W-1:SEL_W*g] = sel_r[2*SEL_W-1:SEL_W];
      assign irq_term[g] = (rise_flag_r[g] & mode_r[DCQ_RIE_BIT]) |
                           (fall_flag_r[g] & mode_r[DCQ_FIE_BIT]);
      assign ctrl_word[g] = {24'h000000, on, sync2_r, rise_flag_r[g], fall_flag_r[g], ctrl_r[3:0]};
      assign mode_word[g] = {24'h000000, mode_r};
      assign sel_word[g]  = {{(32-2*SEL_W){1'b0}}, sel_r};
    end
  endgenerate

  // Interrupt request register
  logic irq_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (|irq_term) & src_en_r & glob_irq_en_r;
    end
  end
  assign cmp_irq = irq_r;

  // ----------------------------------------------------------------
  // Read decode; unmapped reads zero
  // ----------------------------------------------------------------
  assign rd_word = (haddr == DCQ_CTRL_A_OFF) ? ctrl_word[0] :
                   (haddr == DCQ_MODE_A_OFF) ? mode_word[0] :
                   (haddr == DCQ_CTRL_B_OFF) ? ctrl_word[1] :
                   (haddr == DCQ_MODE_B_OFF) ? mode_word[1] :
                   (haddr == DCQ_GLOB_OFF)   ? {30'h0, glob_irq_en_r, src_en_r} :
                   (haddr == 8'h20)          ? sel_word[0] :
                   (haddr == 8'h28)          ? sel_word[1] : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_raw_off;
    @(posedge hclk) disable iff (!hresetn) !core_enable[0] |-> !raw_result[0];
  endproperty
  a_raw_off: assert property (p_raw_off) else $error("raw result high while off");

  property p_sync_off;
    @(posedge hclk) disable iff (!hresetn) !core_enable[0] |=> !sync_result[0];
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync result high after off");

  property p_sync_lat;
    @(posedge hclk) disable iff (!hresetn) (raw_result[0] && core_enable[0]) [*3] |-> sync_result[0];
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("sync result late");

  property p_rise;
    @(posedge hclk) disable iff (!hresetn) $rose(sync_result[0]) |=> rise_flag_r[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rise flag not set");

  property p_fall;
    @(posedge hclk) disable iff (!hresetn) $fell(sync_result[1]) |=> fall_flag_r[1];
  endproperty
  a_fall: assert property (p_fall) else $error("fall flag not set");

  property p_sticky;
    @(posedge hclk) disable iff (!hresetn) (rise_flag_r[0] && !wr_pend_r) |=> rise_flag_r[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("rise flag dropped by itself");

  property p_irq_gate;
    @(posedge hclk) disable iff (!hresetn) !(src_en_r && glob_irq_en_r) |=> !cmp_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enables");

  property p_irq_cause;
    @(posedge hclk) disable iff (!hresetn) cmp_irq |-> $past(|irq_term);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag");

  // Read path must carry the synchronised result, not a stale copy
  property p_status;
    @(posedge hclk) disable iff (!hresetn)
      (rd_take && haddr == DCQ_CTRL_B_OFF) |=> hrdata[DCQ_OUT_BIT] == $past(sync_result[1]);
  endproperty
  a_status: assert property (p_status) else $error("status bit mismatch");

  // ----------------------------------------------------------------
  // Checks above mirrored on the other channel
  // ----------------------------------------------------------------
  property p_raw_off_b;
    @(posedge hclk) disable iff (!hresetn) !core_enable[1] |-> !raw_result[1];
  endproperty
  a_raw_off_b: assert property (p_raw_off_b) else $error("raw result b high while off");

  property p_sync_off_b;
    @(posedge hclk) disable iff (!hresetn) !core_enable[1] |=> !sync_result[1];
  endproperty
  a_sync_off_b: assert property (p_sync_off_b) else $error("sync result b high after off");

  property p_sync_lat_b;
    @(posedge hclk) disable iff (!hresetn) (raw_result[1] && core_enable[1]) [*3] |-> sync_result[1];
  endproperty
  a_sync_lat_b: assert property (p_sync_lat_b) else $error("sync result b late");

  property p_rise_b;
    @(posedge hclk) disable iff (!hresetn) $rose(sync_result[1]) |=> rise_flag_r[1];
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("rise flag b not set");

  property p_fall_a;
    @(posedge hclk) disable iff (!hresetn) $fell(sync_result[0]) |=> fall_flag_r[0];
  endproperty
  a_fall_a: assert property (p_fall_a) else $error("fall flag a not set");

  property p_sticky_b;
    @(posedge hclk) disable iff (!hresetn) (fall_flag_r[1] && !wr_pend_r) |=> fall_flag_r[1];
  endproperty
  a_sticky_b: assert property (p_sticky_b) else $error("fall flag b dropped by itself");

  // ----------------------------------------------------------------
  // Flag sources, clears and the request path
  // ----------------------------------------------------------------
  // A flag with no edge behind it would raise a false interrupt
  property p_rise_src;
    @(posedge hclk) disable iff (!hresetn)
      $rose(rise_flag_r[0]) |-> $past(sync_result[0]) && !$past(sync_result[0], 2);
  endproperty
  a_rise_src: assert property (p_rise_src) else $error("rise flag without rising edge");

  property p_fall_src;
    @(posedge hclk) disable iff (!hresetn)
      $rose(fall_flag_r[1]) |-> !$past(sync_result[1]) && $past(sync_result[1], 2);
  endproperty
  a_fall_src: assert property (p_fall_src) else $error("fall flag without falling edge");

  property p_flag_clr;
    @(posedge hclk) disable iff (!hresetn) (g_cmp[0].rise_clr && !g_cmp[0].rise_det) |=> !rise_flag_r[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("rise flag not cleared by write");

  // Every gate open means the request must follow one edge later
  property p_irq_on;
    @(posedge hclk) disable iff (!hresetn)
      (rise_flag_r[0] && g_cmp[0].mode_r[DCQ_RIE_BIT] && src_en_r && glob_irq_en_r) |=> cmp_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing with all enables set");

  // Write lands on the edge that ends its data phase
  property p_glob_wr;
    @(posedge hclk) disable iff (!hresetn)
      glob_wr |=> (glob_irq_en_r == $past(hwdata[1])) && (src_en_r == $past(hwdata[0]));
  endproperty
  a_glob_wr: assert property (p_glob_wr) else $error("global enables not written");

  // Main scenarios, including a set that races a clear
  c_rise: cover property (@(posedge hclk) disable iff (!hresetn) $rose(rise_flag_r[0]));
  c_fall: cover property (@(posedge hclk) disable iff (!hresetn) $rose(fall_flag_r[1]));
  c_irq:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(cmp_irq));
  c_race: cover property (@(posedge hclk) disable iff (!hresetn) g_cmp[0].rise_det && g_cmp[0].rise_clr);
  c_firq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cmp_irq) && fall_flag_r[1]);

endmodule : dcq_top

/* File: verification/dcq_far_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// Analog comparator cores and interrupt handler
// ------------------------------------------------
module dcq_far_model (
  input  wire logic        hclk,
  input  wire logic [1:0]  core_enable,
  input  wire logic [31:0] pos_mv,
  input  wire logic [31:0] neg_mv,
  input  wire logic        cmp_irq,
  output logic      [1:0]  analog_gt,
  output int               irq_count
);
  logic junk = 1'b0;

  // A powered-down core has no defined output, so it toggles to expose a leaky gate
  always @(posedge hclk) begin
    junk <= ~junk;
  end

  // Each core reports positive above negative while powered
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      analog_gt[i] = core_enable[i] ? (pos_mv[16*i +: 16] > neg_mv[16*i +: 16]) : junk;
    end
  end

  // Handler counts every request it is offered
  initial irq_count = 0;
  always @(posedge cmp_irq) begin
    irq_count++;
  end
endmodule : dcq_far_model

/* File: verification/dcq_top_test.sv */
`timescale 1ns/1ps
module dcq_top_test;
  import dcq_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmp_irq;
  logic [7:0]  haddr, cb, mb, pos_pin_select, neg_pin_select;
  logic [1:0]  htrans, analog_gt, core_enable, raw_result, sync_result;
  logic [2:0]  hsize;
  logic [3:0]  pos_hysteresis_field, neg_hysteresis_field, response_time_field;
  logic [31:0] hwdata, hrdata, pos_mv, neg_mv, rd;
  int          irq_count, n_mismatch, total_checks, ch, g, v;
  logic [7:0]  ra [6] = '{DCQ_CTRL_A_OFF, DCQ_MODE_A_OFF, DCQ_CTRL_B_OFF, DCQ_MODE_B_OFF, DCQ_GLOB_OFF, 8'h30};
  logic [31:0] rv [6] = '{32'h00, 32'h82, 32'h00, 32'h82, 32'h00, 32'h00};

  dcq_top dcq_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .analog_gt(analog_gt), .core_enable(core_enable),
    .pos_hysteresis_field(pos_hysteresis_field), .neg_hysteresis_field(neg_hysteresis_field),
    .response_time_field(response_time_field), .pos_pin_select(pos_pin_select),
    .neg_pin_select(neg_pin_select), .raw_result(raw_result), .sync_result(sync_result), .cmp_irq(cmp_irq));

  dcq_far_model dcq_far_model_inst (.hclk(hclk), .core_enable(core_enable), .pos_mv(pos_mv),
    .neg_mv(neg_mv), .cmp_irq(cmp_irq), .analog_gt(analog_gt), .irq_count(irq_count));

  // ------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_val

  // Bounded wait, so a stuck slave ends the run instead of hanging it
  task wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        final_report();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    xfer(1'b0, a, 32'h0);
    check_val(rd, exp, msg);
  endtask : rd_chk

  // ------------------------------------------------
  // Clock and test sequence
  // ------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, pos_mv, neg_mv} = '0;
    hsize = 3'b010;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i], "reset value");
    check_val(hresp, 1'b0, "okay response");
    $display("test reset values done");
    // Analog says high, but powered-down cores must show nothing
    pos_mv <= 32'h0100_0100;
    repeat (4) @(posedge hclk);
    check_val(raw_result, 2'b00, "raw while off");
    check_val(sync_result, 2'b00, "sync while off");
    $display("test disabled cores done");
    for (ch = 0; ch < 2; ch++) begin
      cb = ch ? DCQ_CTRL_B_OFF : DCQ_CTRL_A_OFF;
      mb = cb + 8'h04;
      pos_mv <= 32'h0;
      neg_mv <= 32'h0080_0080;
      xfer(1'b1, cb, 32'h80);
      repeat (4) @(posedge hclk);
      check_val(core_enable, 2'b01 << ch, "core powered");
      xfer(1'b1, cb, 32'hc0);
      rd_chk(cb, 32'h80, "status read only, flags clear");
      pos_mv[16*ch +: 16] <= 16'h0100;
      #1;
      check_val(raw_result[ch], 1'b1, "raw follows without clock");
      repeat (4) @(posedge hclk);
      check_val(sync_result[ch], 1'b1, "synchronised rise");
      rd_chk(cb, 32'he0, "rise flag with irq off");
      pos_mv[16*ch +: 16] <= 16'h0;
      repeat (4) @(posedge hclk);
      rd_chk(cb, 32'hb0, "rise kept, fall set");
      xfer(1'b1, mb, 32'ha2);
      for (g = 0; g < 4; g++) begin
        xfer(1'b1, DCQ_GLOB_OFF, g);
        repeat (2) @(posedge hclk);
        check_val(cmp_irq, g == 3, "irq gating");
      end
      xfer(1'b1, mb, 32'h82);
      repeat (2) @(posedge hclk);
      check_val(cmp_irq, 1'b0, "no enable, no irq");
      xfer(1'b1, mb, 32'h92);
      repeat (2) @(posedge hclk);
      check_val(cmp_irq, 1'b1, "fall enable raises irq");
      xfer(1'b1, cb, 32'h80);
      repeat (2) @(posedge hclk);
      check_val(cmp_irq, 1'b0, "cleared flags drop irq");
      rd_chk(cb, 32'h80, "flags cleared by write");
      for (v = 0; v < 4; v++) begin
        xfer(1'b1, cb, 32'h80 | (v << 2) | (3 - v));
        xfer(1'b1, mb, 32'h80 | v);
        // The mode write lands on the edge that ends the call; let it settle
        @(posedge hclk);
        check_val(pos_hysteresis_field[2*ch +: 2], v, "pos hysteresis");
        check_val(neg_hysteresis_field[2*ch +: 2], 3 - v, "neg hysteresis");
        check_val(response_time_field[2*ch +: 2], v, "response mode");
      end
      xfer(1'b1, cb, 32'h00);
      xfer(1'b1, DCQ_GLOB_OFF, 32'h0);
      check_val(core_enable, 2'b00, "core powered down");
      $display("test channel %0d done", ch);
    end
    check_val(irq_count, 4, "requests seen by handler");
    xfer(1'b1, 8'h20, 32'h5a);
    xfer(1'b1, 8'h28, 32'hc3);
    @(posedge hclk);
    check_val({pos_pin_select, neg_pin_select}, 16'h3ac5, "pin selects");
    rd_chk(8'h20, 32'h5a, "pin select readback");
    xfer(1'b1, 8'h30, 32'hff);
    rd_chk(8'h30, 32'h0, "unmapped ignored");
    $display("test pin select done");
    final_report();
  end
endmodule : dcq_top_test
